/* logic/ltq_pkg.sv */
package ltq_pkg;
  localparam int           REG_AW       = 6;
  localparam logic [5:0]   A_CTRL       = 6'h00;
  localparam logic [5:0]   A_LEVEL      = 6'h04;
  localparam logic [5:0]   A_PRESET     = 6'h08;
  localparam logic [5:0]   A_SCALE      = 6'h0c;
  localparam logic [5:0]   A_PRECOND    = 6'h10;
  localparam logic [5:0]   A_THR01      = 6'h14;
  localparam logic [5:0]   A_THR23      = 6'h18;
  localparam logic [5:0]   A_ZONE       = 6'h1c;
  localparam logic [5:0]   A_TLIMIT     = 6'h20;
  localparam logic [5:0]   A_HOLDOFF    = 6'h24;
  localparam logic [5:0]   A_STATUS     = 6'h28;
  // Levels are signed millivolts
  localparam logic [15:0]  TTL_MV       = 16'h0578;
  localparam logic [15:0]  ECL_MV       = 16'hfaec;
  localparam logic [4:0]   LEVEL_DIVS   = 5'h0c;
  localparam logic [15:0]  SCALE_RST    = 16'h03e8;
  localparam logic [1:0]   PRE_TTL      = 2'h1;
  localparam logic [1:0]   PRE_ECL      = 2'h2;
  localparam logic [1:0]   PRE_MID      = 2'h3;
  localparam int           CLK_PS       = 5000;
  localparam int           ZONE_MIN_PS  = 2000;
  localparam int           HOLDOFF_PS   = 250000;
  localparam int           ZMC          = (ZONE_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [8:0]   ZONE_MIN_CYC = 9'(ZMC < 1 ? 1 : ZMC);
  localparam logic [31:0]  HOLDOFF_RST  = 32'(HOLDOFF_PS / CLK_PS);
  localparam logic [7:0]   SINCE_MAX    = 8'hff;
  typedef enum logic [1:0] {CLS_PAT, CLS_STATE, CLS_ZONE} ltq_cls_t;
  typedef enum logic [1:0] {FN_AND, FN_NAND, FN_OR, FN_NOR} ltq_fn_t;
  typedef enum logic [1:0] {PC_X, PC_HIGH, PC_LOW} ltq_pc_t;
  typedef enum logic [1:0] {TQ_OFF, TQ_LESS, TQ_MORE} ltq_tq_t;
  typedef enum logic {ST_HOLDOFF, ST_ARMED} ltq_st_t;
  typedef struct packed {
    logic       clk_fall;
    logic [1:0] clk_src;
    logic [1:0] data_src;
    logic [1:0] edge_src;
    logic [1:0] tq;
    logic [1:0] fn;
    logic       goes_false;
    logic       slope_fall;
    logic [1:0] cls;
    logic       logic_type;
  } ltq_ctrl_t;
  typedef struct packed {
    logic signed [7:0] hold;
    logic signed [7:0] setup;
  } ltq_zone_t;
  localparam ltq_ctrl_t    CTRL_RST     = '0;
endpackage : ltq_pkg

/* logic/ltq_trigger.sv */
`timescale 1ns/1ps
// Summary of operation
// - Edge trigger fires only on level crossings in the chosen slope direction.
// - TTL preset loads level +1.4 V, then clamped.
// - ECL preset loads level -1.3 V, then clamped.
// - Level limited to twelve divisions about center.
// - Midpoint preset loads middle of tracked peak-to-peak source swing.
// - Pattern fires as function goes true, or false if chosen; optional timing.
// - Pattern waits for holdoff end then samples all four channels.
// - State samples channels at selected fourth channel edge after holdoff.
// - Function selectable as AND, NAND, OR or NOR.
// - Goes-false swaps AND with NAND and OR with NOR.
// - Pattern uses four inputs; state uses fourth as clock, three as inputs.
// - Zone class has data source, clock source, edge, levels, setup, hold.
// - Data change inside zone around active clock edge triggers.
// - After holdoff, check zone at each clock edge and each data edge; trigger point at the later of the two.
// - Positive setup and hold make zone span the clock edge.
// - Negative setup or hold moves zone wholly after or before edge.
// - Logic classes use per-channel thresholds instead of one level.
// - Each input has high, low or don't care; don't care excluded.
// - Timed pattern measures true span and fires at its false edge.
module ltq_trigger #(
  parameter int SW = 16
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [3:0][SW-1:0]      ch_sample,
  input  wire logic [5:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic                         trig_out,
  output logic                         armed
);
  generate
    if (SW < 16 || SW > 24) begin : g_bad_sw
      $error("ltq_trigger: SW must be 16 to 24");
    end
  endgenerate

  logic [3:0][SW-1:0] ch_s1, ch_s2;
  ltq_pkg::ltq_ctrl_t ctrl, next_ctrl;
  ltq_pkg::ltq_zone_t zone, next_zone;
  ltq_pkg::ltq_st_t   st, next_st;
  logic [SW-1:0]      level_raw, next_level_raw, mx, next_mx, mn, next_mn;
  logic [15:0]        scale, next_scale;
  logic [7:0]         precond, next_precond;
  logic [3:0][15:0]   thr, next_thr;
  logic [31:0]        tlimit, next_tlimit, holdoff, next_holdoff;
  logic [31:0]        hcnt, next_hcnt, tq_cnt, next_tq_cnt, trig_cnt, next_trig_cnt;
  logic [31:0]        next_rdata;
  logic               next_trig;
  logic [3:0]         cmp_q, next_cmp_q, cmp;
  logic               e_q, next_e_q, e_cur, f_q, next_f_q;
  logic [7:0]         since_d, next_since_d, since_c, next_since_c;

  logic signed [SW:0] lim, eff_level;
  logic [20:0]        lim_full;
  logic [SW-1:0]      esrc;
  logic [3:0]         term, used;
  logic               all_t, any_t, fv, fire;
  logic               dcur, ccur, dtr, cedge, sedge;
  logic [7:0]         sd_now, sc_now;
  logic signed [8:0]  s9, h9, lo_c, lo_d;

  always_comb begin
    lim_full = {5'h00, scale} * {16'h0000, ltq_pkg::LEVEL_DIVS};
    // Clamp span saturates at the largest level that a sample can hold
    if (int'(lim_full) > (1 << (SW - 1)) - 1) begin
      lim = (SW+1)'((1 << (SW - 1)) - 1);
    end else begin
      lim = (SW+1)'(lim_full);
    end
    eff_level = (SW+1)'(signed'(level_raw));
    if (eff_level > lim) begin
      eff_level = lim;
    end else if (eff_level < -lim) begin
      eff_level = -lim;
    end
    esrc = ch_s2[ctrl.edge_src];
    // Both sides signed at full width so negative levels compare right
    e_cur = ($signed(esrc) > eff_level) ? 1'b1 : 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmp[i]  = $signed(ch_s2[i]) > $signed(SW'(signed'(thr[i])));
      term[i] = (ltq_pkg::ltq_pc_t'(precond[2*i +: 2]) == ltq_pkg::PC_HIGH) ? cmp[i] : ~cmp[i];
      used[i] = ltq_pkg::ltq_pc_t'(precond[2*i +: 2]) inside {ltq_pkg::PC_HIGH, ltq_pkg::PC_LOW};
    end
    if (ctrl.cls == ltq_pkg::CLS_STATE) begin
      // Fourth channel is the state clock, never a term
      used[3] = 1'b0;
    end
    all_t = &(term | ~used);
    any_t = |(term & used);
    unique case (ltq_pkg::ltq_fn_t'(ctrl.fn))
      ltq_pkg::FN_AND:  fv = all_t;
      ltq_pkg::FN_NAND: fv = ~all_t;
      ltq_pkg::FN_OR:   fv = any_t;
      ltq_pkg::FN_NOR:  fv = ~any_t;
    endcase
    fv = fv ^ ctrl.goes_false;
    dcur  = cmp[ctrl.data_src];
    ccur  = cmp[ctrl.clk_src];
    dtr   = dcur ^ cmp_q[ctrl.data_src];
    cedge = ctrl.clk_fall ? (cmp_q[ctrl.clk_src] & ~ccur) : (~cmp_q[ctrl.clk_src] & ccur);
    sedge = ctrl.clk_fall ? (cmp_q[3] & ~cmp[3]) : (~cmp_q[3] & cmp[3]);
    sd_now = dtr ? 8'h00 : since_d;
    sc_now = cedge ? 8'h00 : since_c;
    s9 = 9'(zone.setup);
    h9 = 9'(zone.hold);
    // Too narrow a zone is widened on the hold side
    if (s9 + h9 < signed'(ltq_pkg::ZONE_MIN_CYC)) begin
      h9 = signed'(ltq_pkg::ZONE_MIN_CYC) - s9;
    end
    lo_c = s9 < 0 ? -s9 : 9'sh000;
    lo_d = h9 < 0 ? -h9 : 9'sh000;
    fire = 1'b0;
    if (ctrl.logic_type == 1'b0) begin
      fire = ctrl.slope_fall ? (e_q & ~e_cur) : (~e_q & e_cur);
    end else begin
      unique case (ctrl.cls)
        ltq_pkg::CLS_PAT: begin
          unique case (ctrl.tq)
            ltq_pkg::TQ_LESS: fire = ~fv & f_q & (tq_cnt < tlimit);
            ltq_pkg::TQ_MORE: fire = ~fv & f_q & (tq_cnt > tlimit);
            default:          fire = fv & ~f_q;
          endcase
        end
        ltq_pkg::CLS_STATE: fire = sedge & fv;
        ltq_pkg::CLS_ZONE: begin
          // Data edge after the clock edge, or clock edge after the data edge
          fire = (dtr & signed'({1'b0, sc_now}) >= lo_c & signed'({1'b0, sc_now}) <= h9)
               | (cedge & signed'({1'b0, sd_now}) >= lo_d
                  & signed'({1'b0, sd_now}) <= s9);
        end
        default: fire = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_ctrl     = ctrl;
    next_zone     = zone;
    next_level_raw = level_raw;
    next_scale    = scale;
    next_precond  = precond;
    next_thr      = thr;
    next_tlimit   = tlimit;
    next_holdoff  = holdoff;
    next_mx       = ($signed(esrc) > $signed(mx)) ? esrc : mx;
    next_mn       = ($signed(esrc) < $signed(mn)) ? esrc : mn;
    // Read data stands for one cycle only
    next_rdata    = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        ltq_pkg::A_CTRL:    next_ctrl = reg_wdata[$bits(ltq_pkg::ltq_ctrl_t)-1:0];
        ltq_pkg::A_LEVEL:   next_level_raw = reg_wdata[SW-1:0];
        ltq_pkg::A_SCALE:   next_scale = reg_wdata[15:0];
        ltq_pkg::A_PRECOND: next_precond = reg_wdata[7:0];
        ltq_pkg::A_THR01:   next_thr[1:0] = reg_wdata;
        ltq_pkg::A_THR23:   next_thr[3:2] = reg_wdata;
        ltq_pkg::A_ZONE:    next_zone = reg_wdata[15:0];
        ltq_pkg::A_TLIMIT:  next_tlimit = reg_wdata;
        ltq_pkg::A_HOLDOFF: next_holdoff = reg_wdata;
        ltq_pkg::A_PRESET: begin
          unique case (reg_wdata[1:0])
            ltq_pkg::PRE_TTL: next_level_raw = SW'(signed'(ltq_pkg::TTL_MV));
            ltq_pkg::PRE_ECL: next_level_raw = SW'(signed'(ltq_pkg::ECL_MV));
            ltq_pkg::PRE_MID: begin
              next_level_raw = SW'((SW+1)'(signed'(mx)) + (SW+1)'(signed'(mn)) >>> 1);
              // Restart tracking so the next midpoint follows the present swing
              next_mx = esrc;
              next_mn = esrc;
            end
            default: next_level_raw = level_raw;
          endcase
        end
        default: next_ctrl = ctrl;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ltq_pkg::A_CTRL:    next_rdata = 32'(ctrl);
        ltq_pkg::A_LEVEL:   next_rdata = 32'(signed'(eff_level));
        ltq_pkg::A_SCALE:   next_rdata = {16'h0000, scale};
        ltq_pkg::A_PRECOND: next_rdata = {24'h000000, precond};
        ltq_pkg::A_THR01:   next_rdata = thr[1:0];
        ltq_pkg::A_THR23:   next_rdata = thr[3:2];
        ltq_pkg::A_ZONE:    next_rdata = {16'h0000, zone};
        ltq_pkg::A_TLIMIT:  next_rdata = tlimit;
        ltq_pkg::A_HOLDOFF: next_rdata = holdoff;
        ltq_pkg::A_STATUS:  next_rdata = {st == ltq_pkg::ST_ARMED, trig_cnt[30:0]};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_st       = st;
    next_hcnt     = hcnt;
    next_trig     = 1'b0;
    next_trig_cnt = trig_cnt;
    next_cmp_q    = cmp;
    next_e_q      = e_cur;
    next_f_q      = fv;
    // Edge distances saturate; that far lies outside any zone
    next_since_d  = dtr ? 8'h01 : (since_d == ltq_pkg::SINCE_MAX ? since_d : since_d + 8'h01);
    next_since_c  = cedge ? 8'h01 : (since_c == ltq_pkg::SINCE_MAX ? since_c : since_c + 8'h01);
    // Saturating true-span count; a very long span still compares as more
    next_tq_cnt   = fv ? ((f_q && tq_cnt != 32'hffff_ffff) ? tq_cnt + 32'h1 : 32'h1) : tq_cnt;
    unique case (st)
      ltq_pkg::ST_HOLDOFF: begin
        // Detectors held clear so nothing seen in holdoff leaks into the armed window
        next_f_q     = 1'b0;
        next_e_q     = e_cur;
        next_tq_cnt  = 32'h0;
        next_since_d = ltq_pkg::SINCE_MAX;
        next_since_c = ltq_pkg::SINCE_MAX;
        if (hcnt == 32'h0) begin
          next_st = ltq_pkg::ST_ARMED;
        end else begin
          next_hcnt = hcnt - 32'h1;
        end
      end
      ltq_pkg::ST_ARMED: begin
        if (fire) begin
          next_trig     = 1'b1;
          next_trig_cnt = trig_cnt + 32'h1;
          next_st       = ltq_pkg::ST_HOLDOFF;
          next_hcnt     = holdoff;
        end
      end
    endcase
  end

  // Samples cross from the digitiser; two stages before any logic sees them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ch_s1     <= '0;
      ch_s2     <= '0;
    end else begin
      ch_s1     <= ch_sample;
      ch_s2     <= ch_s1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl      <= ltq_pkg::CTRL_RST;
      zone      <= '0;
      level_raw <= '0;
      mx        <= '0;
      mn        <= '0;
      scale     <= ltq_pkg::SCALE_RST;
      precond   <= '0;
      thr       <= '0;
      tlimit    <= '0;
      holdoff   <= ltq_pkg::HOLDOFF_RST;
      reg_rdata <= '0;
    end else begin
      ctrl      <= next_ctrl;
      zone      <= next_zone;
      level_raw <= next_level_raw;
      mx        <= next_mx;
      mn        <= next_mn;
      scale     <= next_scale;
      precond   <= next_precond;
      thr       <= next_thr;
      tlimit    <= next_tlimit;
      holdoff   <= next_holdoff;
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st        <= ltq_pkg::ST_HOLDOFF;
      hcnt      <= ltq_pkg::HOLDOFF_RST;
      tq_cnt    <= '0;
      trig_cnt  <= '0;
      cmp_q     <= '0;
      e_q       <= 1'b0;
      f_q       <= 1'b0;
      since_d   <= ltq_pkg::SINCE_MAX;
      since_c   <= ltq_pkg::SINCE_MAX;
      trig_out  <= 1'b0;
      armed     <= 1'b0;
    end else begin
      st        <= next_st;
      hcnt      <= next_hcnt;
      tq_cnt    <= next_tq_cnt;
      trig_cnt  <= next_trig_cnt;
      cmp_q     <= next_cmp_q;
      e_q       <= next_e_q;
      f_q       <= next_f_q;
      since_d   <= next_since_d;
      since_c   <= next_since_c;
      trig_out  <= next_trig;
      armed     <= next_st == ltq_pkg::ST_ARMED;
    end
  end
endmodule : ltq_trigger

/* test/ltq_trigger_props.sv */
`timescale 1ns/1ps
module ltq_trigger_props #(
  parameter int SW = 16
) (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic [3:0][SW-1:0]   ch_sample,
  input wire logic [5:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 trig_out,
  input wire logic                 armed
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_trig_spacing: assert property (trig_out |=> !trig_out [*8])
    else $error("trigger pulses too close");
  a_trig_disarms: assert property (trig_out |-> !armed)
    else $error("armed still high with trigger");
  a_armed_gate: assert property (trig_out |-> $past(armed))
    else $error("trigger fired during holdoff");
  a_holdoff_min: assert property ($fell(armed) |-> !armed [*8])
    else $error("holdoff ended too soon");
  a_rearm_bound: assert property ($fell(armed) |-> ##[1:1000] armed)
    else $error("never rearmed");
  a_status_armed: assert property ($past(reg_rd) && $past(reg_addr) == ltq_pkg::A_STATUS
    |-> reg_rdata[31] == $past(armed))
    else $error("status armed bit wrong");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 6'h3c
    |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : ltq_trigger_props

bind ltq_trigger ltq_trigger_props #(.SW(SW)) i_ltq_trigger_props (
  .core_clk(core_clk), .rst(rst), .ch_sample(ch_sample), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trig_out(trig_out), .armed(armed));

/* test/ltq_probe_model.sv */
`timescale 1ns/1ps
module ltq_probe_model #(
  parameter int SW = 16
) (
  input wire logic                 core_clk,
  input wire logic [3:0]           lvl_hi,
  output logic     [3:0][SW-1:0]   ch_sample
);
  // Probed logic levels as signed mV, well clear of a zero threshold
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      ch_sample[i] <= lvl_hi[i] ? SW'(16'h0100) : SW'(16'hff00);
    end
  end
endmodule : ltq_probe_model

/* test/ltq_trigger_tb_top.sv */
`timescale 1ns/1ps
module ltq_trigger_tb_top;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0]  pre;
    logic [3:0]  b;
    logic [3:0]  a;
    logic        x;
  } ltq_row_t;
  localparam ltq_row_t ROWS [0:19] = '{
    '{16'h0000, 8'h00, 4'h0, 4'h1, 1'b1}, '{16'h0000, 8'h00, 4'h1, 4'h0, 1'b0},
    '{16'h0008, 8'h00, 4'h1, 4'h0, 1'b1}, '{16'h0008, 8'h00, 4'h0, 4'h1, 1'b0},
    '{16'h0001, 8'h05, 4'h1, 4'h3, 1'b1}, '{16'h0001, 8'h05, 4'h0, 4'h1, 1'b0},
    '{16'h0021, 8'h05, 4'h3, 4'h1, 1'b1}, '{16'h0041, 8'h05, 4'h0, 4'h1, 1'b1},
    '{16'h0061, 8'h05, 4'h1, 4'h0, 1'b1}, '{16'h0011, 8'h05, 4'h3, 4'h1, 1'b1},
    '{16'h0031, 8'h05, 4'h1, 4'h3, 1'b1}, '{16'h0051, 8'h05, 4'h1, 4'h0, 1'b1},
    '{16'h0001, 8'h05, 4'hc, 4'h3, 1'b1}, '{16'h0001, 8'h02, 4'h1, 4'h0, 1'b1},
    '{16'h0003, 8'h41, 4'h1, 4'h9, 1'b1}, '{16'h0003, 8'h41, 4'h0, 4'h8, 1'b0},
    '{16'h0003, 8'h41, 4'h0, 4'h1, 1'b0}, '{16'h8003, 8'h41, 4'h9, 4'h1, 1'b1},
    '{16'h0200, 8'h00, 4'h1, 4'h3, 1'b1}, '{16'h0200, 8'h00, 4'h2, 4'h3, 1'b0}
  };
  logic                core_clk;
  logic                rst;
  logic [5:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  logic                trig_out;
  logic                armed;
  logic [3:0]          lvl_hi;
  logic [3:0][15:0]    ch_sample;
  logic                seen;
  int                  errors = 0;
  int                  compares = 0;

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  ltq_probe_model i_ltq_probe_model (.core_clk(core_clk), .lvl_hi(lvl_hi), .ch_sample(ch_sample));
  ltq_trigger i_ltq_trigger (.core_clk(core_clk), .rst(rst), .ch_sample(ch_sample),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_out(trig_out), .armed(armed));

  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata === e, m);
  endtask : rd

  task automatic put(input logic [3:0] v);
    @(posedge core_clk);
    lvl_hi <= v;
  endtask : put

  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      if (trig_out === 1'b1) seen = 1'b1;
    end
  endtask : watch

  // Two passes so a trigger fired at arming has run its holdoff out
  task automatic settle;
    int n;
    repeat (2) begin
      repeat (8) @(negedge core_clk);
      n = 0;
      while (armed !== 1'b1 && n < 200) begin
        @(negedge core_clk);
        n++;
      end
      chk(armed === 1'b1, "not rearmed");
    end
  endtask : settle

  task automatic tq_try(input logic [15:0] c, input int n, input logic e);
    wr(ltq_pkg::A_CTRL, 32'(c));
    put(4'h0);
    settle();
    put(4'h1);
    watch(n);
    chk(seen === 1'b0, "fired while true");
    put(4'h0);
    watch(8);
    chk(seen === e, "timed pattern");
  endtask : tq_try

  // Data on channel 1, clock on channel 2; lead above zero moves data first
  task automatic zn(input int lead, input logic e);
    put(4'h0);
    settle();
    put(lead > 0 ? 4'h1 : 4'h2);
    repeat ((lead > 0 ? lead : -lead) - 1) @(posedge core_clk);
    put(4'h3);
    watch(12);
    chk(seen === e, $sformatf("zone lead %0d", lead));
  endtask : zn

  initial begin
    rst = 1'b1;
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lvl_hi = 4'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(ltq_pkg::A_SCALE, 32'(ltq_pkg::SCALE_RST), "scale reset");
    rd(ltq_pkg::A_HOLDOFF, ltq_pkg::HOLDOFF_RST, "holdoff reset");
    rd(ltq_pkg::A_CTRL, 32'h0, "ctrl reset");
    rd(6'h3c, 32'h0, "unmapped read");
    settle();
    rd(ltq_pkg::A_STATUS, 32'h8000_0000, "status");
    wr(ltq_pkg::A_THR01, 32'h0);
    wr(ltq_pkg::A_THR23, 32'h0);
    wr(ltq_pkg::A_LEVEL, 32'h0);
    foreach (ROWS[i]) begin
      wr(ltq_pkg::A_CTRL, 32'(ROWS[i].ctrl));
      wr(ltq_pkg::A_PRECOND, 32'(ROWS[i].pre));
      put(ROWS[i].b);
      settle();
      put(ROWS[i].a);
      watch(8);
      chk(seen === ROWS[i].x, $sformatf("row %0d", i));
    end
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_TTL));
    rd(ltq_pkg::A_LEVEL, 32'(signed'(ltq_pkg::TTL_MV)), "ttl");
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_ECL));
    rd(ltq_pkg::A_LEVEL, 32'(signed'(ltq_pkg::ECL_MV)), "ecl");
    wr(ltq_pkg::A_SCALE, 32'h64);
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_TTL));
    rd(ltq_pkg::A_LEVEL, 32'h0000_04b0, "ttl clamp");
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_ECL));
    rd(ltq_pkg::A_LEVEL, 32'hffff_fb50, "ecl clamp");
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_MID));
    put(4'h1);
    put(4'h0);
    repeat (4) @(posedge core_clk);
    wr(ltq_pkg::A_PRESET, 32'(ltq_pkg::PRE_MID));
    rd(ltq_pkg::A_LEVEL, 32'h0, "midpoint");
    wr(ltq_pkg::A_SCALE, 32'(ltq_pkg::SCALE_RST));
    wr(ltq_pkg::A_PRECOND, 32'h1);
    wr(ltq_pkg::A_TLIMIT, 32'h5);
    tq_try(16'h0101, 10, 1'b1);
    tq_try(16'h0101, 2, 1'b0);
    tq_try(16'h0081, 2, 1'b1);
    tq_try(16'h0081, 10, 1'b0);
    wr(ltq_pkg::A_CTRL, 32'h2005);
    // Setup and hold both two cycles: a lead of one falls inside the zone, a lead of six outside
    wr(ltq_pkg::A_ZONE, 32'h0202);
    zn(1, 1'b1);
    zn(6, 1'b0);
    zn(-1, 1'b1);
    zn(-6, 1'b0);
    wr(ltq_pkg::A_ZONE, 32'h05fe);
    zn(-3, 1'b1);
    zn(1, 1'b0);
    wr(ltq_pkg::A_ZONE, 32'h0000);
    zn(-1, 1'b1);
    // Channel 2 reads low only through its own higher threshold
    wr(ltq_pkg::A_THR01, 32'h0200_0000);
    wr(ltq_pkg::A_PRECOND, 32'h9);
    wr(ltq_pkg::A_CTRL, 32'h1);
    put(4'h0);
    settle();
    put(4'h3);
    watch(8);
    chk(seen === 1'b1, "channel threshold");
    wr(ltq_pkg::A_THR01, 32'h0);
    wr(ltq_pkg::A_PRECOND, 32'h1);
    wr(ltq_pkg::A_CTRL, 32'h1);
    put(4'h0);
    settle();
    put(4'h1);
    watch(6);
    chk(seen === 1'b1, "first pattern");
    put(4'h0);
    put(4'h1);
    watch(40);
    chk(seen === 1'b0, "fired in holdoff");
    watch(30);
    chk(seen === 1'b1, "true at arming");
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk(armed === 1'b0 && trig_out === 1'b0 && reg_rdata === 32'h0, "reset outputs");
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (40) @(negedge core_clk);
    chk(armed === 1'b0, "early arm");
    repeat (20) @(negedge core_clk);
    chk(armed === 1'b1, "late arm");
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    complete_run();
  end
endmodule : ltq_trigger_tb_top
